// ==== verilog/ckp_pkg.sv ====
package ckp_pkg;

  // register byte offsets
  localparam logic [7:0] CFG_OFS = 8'h04;
  localparam logic [7:0] INT_OFS = 8'h08;

  // configuration register field positions
  localparam int CFG_SEL_LSB  = 0;
  localparam int CFG_STS_LSB  = 2;
  localparam int CFG_BUS_LSB  = 4;
  localparam int CFG_SLOW_LSB = 8;
  localparam int CFG_FAST_LSB = 11;
  localparam int CFG_SUPV_BIT = 16;

  // clock interrupt register field positions
  localparam int INT_FLAG_LSB = 0;
  localparam int INT_FAIL_BIT = 7;
  localparam int INT_IE_LSB   = 8;
  localparam int INT_CLR_LSB  = 16;
  localparam int INT_FCLR_BIT = 23;

  // ready sources, same order in flags, enables and clears
  localparam int RDY_LSI = 0;
  localparam int RDY_LSE = 1;
  localparam int RDY_IFAST = 2;
  localparam int RDY_EFAST = 3;
  localparam int RDY_PLL = 4;
  localparam int RDY_N   = 5;

  // reset values
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] INT_RST = 32'h0000_0000;

  // divider sizing: largest divide is 512
  localparam int DIV_SHIFT_W = 4;
  localparam int DIV_CNT_W   = 9;

  // system clock sources
  typedef enum logic [1:0] {
    CKP_SRC_RC  = 2'h0,
    CKP_SRC_EXT = 2'h1,
    CKP_SRC_PLL = 2'h2,
    CKP_SRC_BAD = 2'h3
  } ckp_src_t;

  // peripheral prescaler code to shift amount (0xx -> 0, 1xx -> 1..4)
  function automatic logic [DIV_SHIFT_W-1:0] periph_shift(input logic [2:0] code);
    periph_shift = code[2] ? DIV_SHIFT_W'({2'h0, code[1:0]} + 4'h1) : 4'h0;
  endfunction : periph_shift

  // bus prescaler code to shift amount (1000..1011 -> 1..4, 1100..1111 -> 6..9)
  function automatic logic [DIV_SHIFT_W-1:0] bus_shift(input logic [3:0] code);
    if (!code[3]) begin
      bus_shift = 4'h0;
    end else if (!code[2]) begin
      bus_shift = DIV_SHIFT_W'({2'h0, code[1:0]} + 4'h1);
    end else begin
      bus_shift = DIV_SHIFT_W'({2'h0, code[1:0]} + 4'h6);
    end
  endfunction : bus_shift

  // byte enables widened to a bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

endpackage : ckp_pkg

// ==== verilog/ckp_sync.sv ====
`timescale 1ns/100ps
module ckp_sync #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // two stages; only the second stage is read outside
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule : ckp_sync

// ==== verilog/ckp_clk_div.sv ====
`timescale 1ns/100ps
module ckp_clk_div #(
  parameter int SHIFT_W = ckp_pkg::DIV_SHIFT_W,
  parameter int CNT_W   = ckp_pkg::DIV_CNT_W
) (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               in_en,
  input  wire logic [SHIFT_W-1:0] shift,
  output logic                    out_en
);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] limit;
  logic             wrap;

  // divide by 2**shift; >= so a shrinking ratio never strands the count
  assign limit   = CNT_W'((32'd1 << shift) - 32'd1);
  assign wrap    = (cnt_ff >= limit);
  assign out_en  = in_en & wrap;
  assign nxt_cnt = wrap ? '0 : CNT_W'(cnt_ff + 1'b1);

  // count input enables only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (in_en) begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule : ckp_clk_div

// ==== verilog/ckp_clock_ctrl.sv ====
`timescale 1ns/100ps
// What this block does
// - fast peripheral prescaler: 0xx undivided, 100..111 divide bus clock by 2,4,8,16.
// - slow peripheral prescaler in bits 10:8, same encoding as the fast one.
// - bus prescaler bits 7:4: 0xxx undivided, then 2,4,8,16,64,128,256,512.
// - read-only status bits 3:2 show the active system clock source.
// - select bits 1:0 choose RC, external or PLL; code 11 is never used.
// - with supervision, force internal RC on low-power exit or on external failure while it feeds the system clock.
// - clock interrupt register at 0x08, resets to zero, any width, no waits.
// - writing one to bit 23 clears the clock-failure flag; zero does nothing.
// - writing one to bit 20 clears the PLL ready flag; zero does nothing.
// - bits 19..16 clear external fast, internal fast, external slow, internal slow flags.
// - reserved interrupt register bits 31:24, 22:21, 15:13 read as zero.
// - bit 12 enables the PLL ready interrupt.
// - clock-failure flag sets on external oscillator failure, stays until cleared.
module ckp_clock_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic [3:0]  reg_be,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [4:0]  osc_ready_in,
  input  wire logic        ext_osc_fail_in,
  input  wire logic        low_power_exit_in,
  input  wire logic        pll_from_ext_in,
  output logic      [1:0]  sys_clk_mux_sel,
  output logic             bus_clk_en,
  output logic             fast_periph_clk_en,
  output logic             slow_periph_clk_en,
  output logic             clk_irq
);

  localparam int N = ckp_pkg::RDY_N;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [7:0]   pins_sync;
  logic [N-1:0] rdy_lvl;
  logic         fail_lvl;
  logic         lpx_lvl;
  logic         pll_ext_lvl;

  ckp_sync #(
    .W (8)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({pll_from_ext_in, low_power_exit_in, ext_osc_fail_in, osc_ready_in}),
    .sync_out (pins_sync)
  );

  // unpack synchronised levels
  assign rdy_lvl     = pins_sync[N-1:0];
  assign fail_lvl    = pins_sync[5];
  assign lpx_lvl     = pins_sync[6];
  assign pll_ext_lvl = pins_sync[7];

  // edge detectors work on synchronised copies only
  logic [N-1:0] rdy_prev_ff;
  logic         fail_prev_ff;
  logic         lpx_prev_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdy_prev_ff  <= '0;
      fail_prev_ff <= 1'b0;
      lpx_prev_ff  <= 1'b0;
    end else begin
      rdy_prev_ff  <= rdy_lvl;
      fail_prev_ff <= fail_lvl;
      lpx_prev_ff  <= lpx_lvl;
    end
  end

  // one-cycle events
  logic [N-1:0] rdy_rise;
  logic         fail_rise;
  logic         lpx_rise;

  assign rdy_rise  = rdy_lvl & ~rdy_prev_ff;
  assign fail_rise = fail_lvl & ~fail_prev_ff;
  assign lpx_rise  = lpx_lvl & ~lpx_prev_ff;

  // ---------------------------------------------------------------
  // register bus decode
  // ---------------------------------------------------------------
  logic        hit_cfg;
  logic        hit_int;
  logic        wr_cfg;
  logic        wr_int;
  logic [31:0] wmask;

  assign hit_cfg = (reg_addr == ckp_pkg::CFG_OFS);
  assign hit_int = (reg_addr == ckp_pkg::INT_OFS);
  assign wr_cfg  = reg_wr & hit_cfg;
  assign wr_int  = reg_wr & hit_int;
  assign wmask   = ckp_pkg::be_mask(reg_be);

  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  logic [2:0] fast_psc_ff;
  logic [2:0] slow_psc_ff;
  logic [3:0] bus_psc_ff;
  logic [1:0] sel_ff;
  logic [1:0] sts_ff;
  logic       supv_en_ff;

  logic [31:0] cfg_cur;
  logic [31:0] cfg_merged;
  logic [2:0]  nxt_fast_psc;
  logic [2:0]  nxt_slow_psc;
  logic [3:0]  nxt_bus_psc;
  logic        nxt_supv_en;
  logic [1:0]  wr_sel;
  logic        wr_sel_ok;

  // current word with explicit operands, so the merge tracks every field change
  assign cfg_cur    = cfg_word(fast_psc_ff, slow_psc_ff, bus_psc_ff,
                               sts_ff, sel_ff, supv_en_ff);
  // byte-lane merge of the current value with the write data
  assign cfg_merged = (cfg_cur & ~wmask) | (reg_wdata & wmask);

  assign nxt_fast_psc = wr_cfg ? cfg_merged[ckp_pkg::CFG_FAST_LSB +: 3] : fast_psc_ff;
  assign nxt_slow_psc = wr_cfg ? cfg_merged[ckp_pkg::CFG_SLOW_LSB +: 3] : slow_psc_ff;
  assign nxt_bus_psc  = wr_cfg ? cfg_merged[ckp_pkg::CFG_BUS_LSB +: 4] : bus_psc_ff;
  assign nxt_supv_en  = wr_cfg ? cfg_merged[ckp_pkg::CFG_SUPV_BIT] : supv_en_ff;

  // code 11 is refused and the old choice kept
  assign wr_sel    = cfg_merged[ckp_pkg::CFG_SEL_LSB +: 2];
  assign wr_sel_ok = wr_cfg & (wr_sel != ckp_pkg::CKP_SRC_BAD);

  // forced fallback to the internal RC oscillator
  logic ext_feeds_sys;
  logic force_rc;

  assign ext_feeds_sys = (sts_ff == ckp_pkg::CKP_SRC_EXT) |
                         ((sts_ff == ckp_pkg::CKP_SRC_PLL) & pll_ext_lvl);
  assign force_rc      = supv_en_ff & (lpx_rise | (fail_rise & ext_feeds_sys));

  // select: forcing outranks a software write in the same cycle
  logic [1:0] nxt_sel;

  assign nxt_sel = force_rc ? ckp_pkg::CKP_SRC_RC :
                   wr_sel_ok ? wr_sel : sel_ff;

  // status follows the selection once that source is ready
  logic       tgt_ready;
  logic [1:0] nxt_sts;

  assign tgt_ready = (sel_ff == ckp_pkg::CKP_SRC_RC)  ? rdy_lvl[ckp_pkg::RDY_IFAST] :
                     (sel_ff == ckp_pkg::CKP_SRC_EXT) ? rdy_lvl[ckp_pkg::RDY_EFAST] :
                     (sel_ff == ckp_pkg::CKP_SRC_PLL) ? rdy_lvl[ckp_pkg::RDY_PLL] : 1'b0;
  assign nxt_sts   = force_rc ? ckp_pkg::CKP_SRC_RC :
                     tgt_ready ? sel_ff : sts_ff;

  // configuration state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fast_psc_ff <= ckp_pkg::CFG_RST[ckp_pkg::CFG_FAST_LSB +: 3];
      slow_psc_ff <= ckp_pkg::CFG_RST[ckp_pkg::CFG_SLOW_LSB +: 3];
      bus_psc_ff  <= ckp_pkg::CFG_RST[ckp_pkg::CFG_BUS_LSB +: 4];
      sel_ff      <= ckp_pkg::CFG_RST[ckp_pkg::CFG_SEL_LSB +: 2];
      sts_ff      <= ckp_pkg::CFG_RST[ckp_pkg::CFG_STS_LSB +: 2];
      supv_en_ff  <= ckp_pkg::CFG_RST[ckp_pkg::CFG_SUPV_BIT];
    end else begin
      fast_psc_ff <= nxt_fast_psc;
      slow_psc_ff <= nxt_slow_psc;
      bus_psc_ff  <= nxt_bus_psc;
      sel_ff      <= nxt_sel;
      sts_ff      <= nxt_sts;
      supv_en_ff  <= nxt_supv_en;
    end
  end

  // the mux follows status: a selected source only once it is ready, internal RC at once when forced
  assign sys_clk_mux_sel = sts_ff;

  // current configuration word
  function automatic logic [31:0] cfg_word(input logic [2:0] fp,
                                           input logic [2:0] sp,
                                           input logic [3:0] bp,
                                           input logic [1:0] st,
                                           input logic [1:0] sl,
                                           input logic       sv);
    cfg_word = {15'h0000, sv, 2'h0, fp, sp, bp, st, sl};
  endfunction : cfg_word

  // ---------------------------------------------------------------
  // clock enable dividers
  // ---------------------------------------------------------------
  logic [ckp_pkg::DIV_SHIFT_W-1:0] bus_sh;
  logic [ckp_pkg::DIV_SHIFT_W-1:0] fast_sh;
  logic [ckp_pkg::DIV_SHIFT_W-1:0] slow_sh;

  assign bus_sh  = ckp_pkg::bus_shift(bus_psc_ff);
  assign fast_sh = ckp_pkg::periph_shift(fast_psc_ff);
  assign slow_sh = ckp_pkg::periph_shift(slow_psc_ff);

  // bus enable is derived from the system clock
  ckp_clk_div u_div_bus (
    .sys_clk (sys_clk),
    .rst     (rst),
    .in_en   (1'b1),
    .shift   (bus_sh),
    .out_en  (bus_clk_en)
  );

  // peripheral enables divide the bus enable further
  ckp_clk_div u_div_fast (
    .sys_clk (sys_clk),
    .rst     (rst),
    .in_en   (bus_clk_en),
    .shift   (fast_sh),
    .out_en  (fast_periph_clk_en)
  );

  ckp_clk_div u_div_slow (
    .sys_clk (sys_clk),
    .rst     (rst),
    .in_en   (bus_clk_en),
    .shift   (slow_sh),
    .out_en  (slow_periph_clk_en)
  );

  // ---------------------------------------------------------------
  // clock interrupt register
  // ---------------------------------------------------------------
  logic [N-1:0] rdy_flag_ff;
  logic [N-1:0] rdy_ie_ff;
  logic         fail_flag_ff;

  logic [N-1:0] rdy_clr;
  logic         fail_clr;
  logic [N-1:0] nxt_rdy_flag;
  logic [N-1:0] nxt_rdy_ie;
  logic         nxt_fail_flag;

  assign rdy_clr  = {N{wr_int}} & reg_wdata[ckp_pkg::INT_CLR_LSB +: N] &
                    wmask[ckp_pkg::INT_CLR_LSB +: N];
  assign fail_clr = wr_int & reg_wdata[ckp_pkg::INT_FCLR_BIT] &
                    wmask[ckp_pkg::INT_FCLR_BIT];

  // set beats clear so a ready edge in the clearing cycle is kept
  assign nxt_rdy_flag  = (rdy_flag_ff & ~rdy_clr) | rdy_rise;
  assign nxt_fail_flag = (fail_flag_ff & ~fail_clr) | fail_rise;

  assign nxt_rdy_ie = wr_int ?
                      ((rdy_ie_ff & ~wmask[ckp_pkg::INT_IE_LSB +: N]) |
                       (reg_wdata[ckp_pkg::INT_IE_LSB +: N] &
                        wmask[ckp_pkg::INT_IE_LSB +: N])) :
                      rdy_ie_ff;

  // interrupt register state resets to zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdy_flag_ff  <= ckp_pkg::INT_RST[ckp_pkg::INT_FLAG_LSB +: N];
      rdy_ie_ff    <= ckp_pkg::INT_RST[ckp_pkg::INT_IE_LSB +: N];
      fail_flag_ff <= ckp_pkg::INT_RST[ckp_pkg::INT_FAIL_BIT];
    end else begin
      rdy_flag_ff  <= nxt_rdy_flag;
      rdy_ie_ff    <= nxt_rdy_ie;
      fail_flag_ff <= nxt_fail_flag;
    end
  end

  // level interrupt; failure is never masked
  assign clk_irq = fail_flag_ff | (|(rdy_flag_ff & rdy_ie_ff));

  // reserved and clear bits read as zero
  logic [31:0] int_word;

  assign int_word = {19'h00000, rdy_ie_ff, fail_flag_ff, 2'h0, rdy_flag_ff};

  // ---------------------------------------------------------------
  // read data, one cycle after the strobe; unmapped reads zero
  // ---------------------------------------------------------------
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  assign nxt_rdata = !reg_rd ? 32'h0000_0000 :
                     hit_cfg ? cfg_cur :
                     hit_int ? int_word : 32'h0000_0000;

  // data stands only in the cycle after the read strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // software obligations are not checked in hardware:
  // peripheral clocks under 90 MHz, prefetch kept on when divided

endmodule : ckp_clock_ctrl

// ==== testbench/ckp_clock_ctrl_asserts.sv ====
`timescale 1ns/100ps
// port-level checks on the clock control block
module ckp_clock_ctrl_asserts (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [3:0]  reg_be,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [4:0]  osc_ready_in,
  input wire logic        ext_osc_fail_in,
  input wire logic        low_power_exit_in,
  input wire logic        pll_from_ext_in,
  input wire logic [1:0]  sys_clk_mux_sel,
  input wire logic        bus_clk_en,
  input wire logic        fast_periph_clk_en,
  input wire logic        slow_periph_clk_en,
  input wire logic        clk_irq
);
  logic       supv_ff;
  logic [3:0] bus_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // shadow of supervision and bus code; assumes full-word config writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      supv_ff <= 1'b0;
      bus_ff  <= 4'h0;
    end else if (reg_wr && reg_addr == ckp_pkg::CFG_OFS) begin
      supv_ff <= reg_wdata[16];
      bus_ff  <= reg_wdata[7:4];
    end
  end

  // divide-by-two enable pattern
  sequence s_half;
    !bus_clk_en ##1 bus_clk_en;
  endsequence

  sequence s_int_rd;
    $past(reg_rd) && $past(reg_addr) == ckp_pkg::INT_OFS;
  endsequence

  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read cycle");
  chk_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) != ckp_pkg::CFG_OFS
    && $past(reg_addr) != ckp_pkg::INT_OFS |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_reserved_zero: assert property (s_int_rd |-> reg_rdata[31:13] == 19'h0)
    else $error("reserved or clear bits read nonzero");
  chk_irq_flags: assert property (s_int_rd |-> $past(clk_irq) ==
    (reg_rdata[7] | (|(reg_rdata[4:0] & reg_rdata[12:8]))))
    else $error("interrupt level disagrees with flags");
  chk_status_mux: assert property ($past(reg_rd) && $past(reg_addr) == ckp_pkg::CFG_OFS
    |-> reg_rdata[3:2] == $past(sys_clk_mux_sel))
    else $error("status field disagrees with mux select");
  chk_sel_legal: assert property (sys_clk_mux_sel != 2'h3)
    else $error("illegal source select");
  chk_bus_undiv: assert property (!bus_ff[3] && !$past(bus_ff[3]) |-> bus_clk_en)
    else $error("bus enable gapped while undivided");
  chk_bus_half: assert property ((bus_ff == 4'h8 && $past(bus_ff, 3) == 4'h8
    && !reg_wr && bus_clk_en) ##1 !reg_wr |-> s_half)
    else $error("bus divide by two broken");
  chk_fast_subset: assert property (fast_periph_clk_en |-> bus_clk_en)
    else $error("fast enable outside bus enable");
  chk_slow_subset: assert property (slow_periph_clk_en |-> bus_clk_en)
    else $error("slow enable outside bus enable");
  chk_force_exit: assert property ($rose(low_power_exit_in) && supv_ff
    |-> ##[2:6] sys_clk_mux_sel == 2'h0)
    else $error("no forced switch on low-power exit");
  chk_fail_irq: assert property ($rose(ext_osc_fail_in) |-> ##[2:6] clk_irq)
    else $error("oscillator failure raised no interrupt");
endmodule : ckp_clock_ctrl_asserts

bind ckp_clock_ctrl ckp_clock_ctrl_asserts u_chk (.sys_clk, .rst, .reg_addr, .reg_wdata,
  .reg_be, .reg_wr, .reg_rd, .reg_rdata, .osc_ready_in, .ext_osc_fail_in, .low_power_exit_in,
  .pll_from_ext_in, .sys_clk_mux_sel, .bus_clk_en, .fast_periph_clk_en, .slow_periph_clk_en,
  .clk_irq);

// ==== testbench/ckp_clock_ctrl_tb.sv ====
`timescale 1ns/100ps
// register port driven directly; clock enables counted
module ckp_clock_ctrl_tb;
  localparam logic [7:0] CFG = ckp_pkg::CFG_OFS;
  localparam logic [7:0] INT = ckp_pkg::INT_OFS;
  logic        sys_clk = 1'b0;
  logic        rst, reg_wr, reg_rd, ext_osc_fail_in, low_power_exit_in, pll_from_ext_in;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [3:0]  reg_be;
  logic [4:0]  osc_ready_in;
  logic [1:0]  sys_clk_mux_sel;
  logic        bus_clk_en, fast_periph_clk_en, slow_periph_clk_en, clk_irq;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          nb, nf, ns;
  int          bsh[16] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 2, 3, 4, 6, 7, 8, 9};
  int          psh[8] = '{0, 0, 0, 0, 1, 2, 3, 4};

  ckp_clock_ctrl DUT (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_be, .reg_wr, .reg_rd,
    .reg_rdata, .osc_ready_in, .ext_osc_fail_in, .low_power_exit_in, .pll_from_ext_in,
    .sys_clk_mux_sel, .bus_clk_en, .fast_periph_clk_en, .slow_periph_clk_en, .clk_irq);

  // 200 MHz
  always #2.5 sys_clk = ~sys_clk;

  // hang guard; the divider sweep dominates the run
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch = n_mismatch + 1;
      final_report();
    end
  end

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_be    <= be;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 rv = reg_rdata;
    chk(rv, e);
  endtask : rc

  // exact counts: every divide is a power of two that divides the window
  task automatic cnt(input int n);
    nb = 0;
    nf = 0;
    ns = 0;
    repeat (4) @(posedge sys_clk);
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      nb += int'(bus_clk_en);
      nf += int'(fast_periph_clk_en);
      ns += int'(slow_periph_clk_en);
    end
  endtask : cnt

  task automatic irq_is(input logic e);
    #1 chk({31'h0, clk_irq}, {31'h0, e});
  endtask : irq_is

  initial begin
    {rst, reg_wr, reg_rd, ext_osc_fail_in, low_power_exit_in, pll_from_ext_in} = 6'h20;
    {reg_addr, reg_wdata, reg_be, osc_ready_in} = '0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rc(INT, 32'h0);
    rc(8'h0c, 32'h0);
    // software duties: divide settings here are exercised, not rated
    // every bus prescaler code
    for (int c = 0; c < 16; c++) begin
      wr(CFG, 32'(c) << 4, 4'hf);
      cnt(1024);
      chk(32'(nb), 32'(1024 >> bsh[c]));
    end
    // every peripheral prescaler code, both fields at once
    for (int p = 0; p < 8; p++) begin
      wr(CFG, (32'(p) << 11) | (32'(p) << 8), 4'hf);
      cnt(64);
      chk(32'(nf), 32'(64 >> psh[p]));
      chk(32'(ns), 32'(64 >> psh[p]));
    end
    // fast divide stacked on a divided bus clock
    wr(CFG, 32'h0000_2880, 4'hf);
    cnt(64);
    chk(32'(nf), 32'h8);
    rc(CFG, 32'h0000_2880);
    wr(CFG, 32'h3, 4'hf);
    rc(CFG, 32'h0);
    // ready flags latch; only the PLL enable reaches the interrupt
    osc_ready_in <= 5'h1f;
    repeat (6) @(posedge sys_clk);
    rc(INT, 32'h1f);
    irq_is(1'b0);
    wr(INT, 32'h0000_1000, 4'hf);
    irq_is(1'b1);
    wr(INT, 32'h0010_1000, 4'hb);
    irq_is(1'b1);
    wr(INT, 32'h0010_0000, 4'h4);
    irq_is(1'b0);
    rc(INT, 32'h0000_100f);
    wr(INT, 32'h000f_0000, 4'h4);
    rc(INT, 32'h0000_1000);
    // source switching follows select and ready
    wr(CFG, 32'h1, 4'hf);
    rc(CFG, 32'h5);
    wr(CFG, 32'h2, 4'hf);
    rc(CFG, 32'ha);
    // failure of the external source while it feeds the system clock
    wr(CFG, 32'h0001_0001, 4'hf);
    rc(CFG, 32'h0001_0005);
    ext_osc_fail_in <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rc(CFG, 32'h0001_0000);
    rc(INT, 32'h0000_1080);
    irq_is(1'b1);
    wr(INT, 32'h0080_0000, 4'h4);
    irq_is(1'b0);
    // low-power exit forces the internal source
    wr(CFG, 32'h0001_0002, 4'hf);
    rc(CFG, 32'h0001_000a);
    low_power_exit_in <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 chk({30'h0, sys_clk_mux_sel}, 32'h0);
    // failure while the PLL runs from the external oscillator
    {ext_osc_fail_in, pll_from_ext_in} <= 2'b01;
    repeat (4) @(posedge sys_clk);
    wr(CFG, 32'h0001_0002, 4'hf);
    rc(CFG, 32'h0001_000a);
    ext_osc_fail_in <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 chk({30'h0, sys_clk_mux_sel}, 32'h0);
    irq_is(1'b1);
    @(posedge sys_clk);
    pll_from_ext_in <= 1'b0;
    // second reset mid-run
    {osc_ready_in, ext_osc_fail_in, low_power_exit_in} <= '0;
    rst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rc(INT, 32'h0);
    rc(CFG, 32'h0);
    final_report();
  end
endmodule : ckp_clock_ctrl_tb
